/* tb/testbench.sv */
// self-checking bench of the preset counter unit
// assumes pdc_pkg and pdc_counter are compiled first; one 200 MHz clock
`timescale 1ns/1ps
`define CHK(got, exp) begin \
  checks_done++; \
  if ((got) !== (exp)) begin \
    mismatches++; \
    $display("unexpected at %0t: got %h expected %h", $time, got, exp); \
  end \
end
module testbench;
  import pdc_pkg::*;
  logic clock;
  logic rst;
  pdc_bus_type bus;
  logic [31:0] rd_data;
  pdc_pins_type pins;
  logic exec_strobe;
  logic interlock;
  logic dn_done;
  logic ud_done;
  logic operand_error_flag;
  logic irq;
  int mismatches;
  int checks_done;
  int seed;
  int n;
  int k;
  int p;
  int cnt;
  logic [31:0] x;
  logic [4:0] v;
  logic [4:0] pv;
  logic ri;
  logic rf;

  pdc_counter DUT (
    .clock(clock),
    .rst(rst),
    .bus(bus),
    .rd_data(rd_data),
    .pins(pins),
    .exec_strobe(exec_strobe),
    .interlock(interlock),
    .dn_done(dn_done),
    .ud_done(ud_done),
    .operand_error_flag(operand_error_flag),
    .irq(irq)
  );

  initial clock = 1'b0;
  always #2.5 clock = ~clock;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] i2b(input int val);
    logic [31:0] r;
    r = '0;
    for (int i = 0; i < 4; i++) begin
      r[i*4 +: 4] = 4'(val % 10);
      val = val / 10;
    end
    return r;
  endfunction : i2b

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    bus.wr <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic chk_reg(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    @(posedge clock);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    bus.rd <= 1'b0;
    #1;
    d = rd_data;
    `CHK(d, e)
  endtask : chk_reg

  // pins bits: count pulse, down reset, inc, dec, reversible reset;
  // held 4 clocks so the two sync flops settle before the execution
  task automatic step(input logic [4:0] pp, input logic il);
    @(posedge clock);
    pins <= pdc_pins_type'(pp);
    interlock <= il;
    repeat (4) @(posedge clock);
    exec_strobe <= 1'b1;
    @(posedge clock);
    exec_strobe <= 1'b0;
    interlock <= 1'b0;
    @(posedge clock);
  endtask : step

  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : final_report

  // watchdog: a hang counts as a mismatch
  initial begin
    repeat (100000) @(posedge clock);
    mismatches++;
    final_report();
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    seed = 50;
    mismatches = 0;
    checks_done = 0;
    rst = 1'b1;
    bus = '0;
    pins = '0;
    exec_strobe = 1'b0;
    interlock = 1'b0;
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    chk_reg(PDC_DN_PRESET_OFS, 32'h0);
    chk_reg(PDC_UD_COUNT_OFS, 32'h0);
    chk_reg(PDC_STATUS_OFS, 32'h1);
    chk_reg(PDC_FLAGS_OFS, 32'h1);
    wr(8'h1c, 32'hffff_ffff);
    chk_reg(8'h1c, 32'h0);
    wr(PDC_DN_PRESET_OFS, 32'hffff_9999);
    chk_reg(PDC_DN_PRESET_OFS, 32'h9999);
    wr(PDC_DN_COUNT_OFS, 32'h1234);
    chk_reg(PDC_DN_COUNT_OFS, 32'h0);
    $display("test registers done");

    // down counter; preset above 9 so a digit borrow is crossed
    n = 10 + {$random(seed)} % 3;
    wr(PDC_DN_PRESET_OFS, i2b(n));
    step(5'b01000, 1'b0);
    chk_reg(PDC_DN_COUNT_OFS, i2b(n));
    `CHK(dn_done, 1'b0)
    step(5'b11000, 1'b0);
    chk_reg(PDC_DN_COUNT_OFS, i2b(n));
    step(5'b00000, 1'b0);
    chk_reg(PDC_DN_COUNT_OFS, i2b(n));
    @(posedge clock);
    pins <= pdc_pins_type'(5'b10000);
    repeat (4) @(posedge clock);
    pins <= '0;
    step(5'b00000, 1'b0);
    chk_reg(PDC_DN_COUNT_OFS, i2b(n));
    step(5'b10100, 1'b1);
    chk_reg(PDC_DN_COUNT_OFS, i2b(n));
    chk_reg(PDC_UD_COUNT_OFS, 32'h0);
    for (k = 1; k <= n; k++) begin
      step(5'b10000, 1'b0);
      chk_reg(PDC_DN_COUNT_OFS, i2b(n - k));
      step(5'b10000, 1'b0);
      chk_reg(PDC_DN_COUNT_OFS, i2b(n - k));
      step(5'b00000, 1'b0);
    end
    `CHK(dn_done, 1'b1)
    step(5'b10000, 1'b0);
    chk_reg(PDC_DN_COUNT_OFS, 32'h0);
    `CHK(dn_done, 1'b1)
    step(5'b00000, 1'b0);
    $display("test down counter done");

    // reversible counter corners
    p = 2 + {$random(seed)} % 4;
    wr(PDC_UD_PRESET_OFS, i2b(p));
    step(5'b00001, 1'b0);
    chk_reg(PDC_UD_COUNT_OFS, 32'h0);
    step(5'b00101, 1'b0);
    chk_reg(PDC_UD_COUNT_OFS, 32'h0);
    step(5'b00000, 1'b0);
    step(5'b00010, 1'b0);
    chk_reg(PDC_UD_COUNT_OFS, i2b(p));
    `CHK(ud_done, 1'b1)
    step(5'b00000, 1'b0);
    step(5'b00100, 1'b0);
    chk_reg(PDC_UD_COUNT_OFS, 32'h0);
    `CHK(ud_done, 1'b1)
    step(5'b00000, 1'b0);
    step(5'b00100, 1'b0);
    chk_reg(PDC_UD_COUNT_OFS, 32'h1);
    `CHK(ud_done, 1'b0)
    step(5'b00000, 1'b0);
    step(5'b00110, 1'b0);
    chk_reg(PDC_UD_COUNT_OFS, 32'h1);
    step(5'b00000, 1'b0);
    $display("test reversible corners done");

    // random levels on both count inputs against a bench model
    cnt = 1;
    pv = 5'b00000;
    for (k = 0; k < 30; k++) begin
      x = $random(seed);
      v = {2'b00, x[1], x[0], 1'b0};
      ri = v[2] & ~pv[2];
      rf = v[1] & ~pv[1];
      step(v, 1'b0);
      if (ri && !rf) begin
        cnt = (cnt >= p) ? 0 : cnt + 1;
        `CHK(ud_done, 1'(cnt == 0))
      end else if (rf && !ri) begin
        cnt = (cnt == 0) ? p : cnt - 1;
        `CHK(ud_done, 1'(cnt == p))
      end
      chk_reg(PDC_UD_COUNT_OFS, i2b(cnt));
      pv = v;
    end
    $display("test reversible random done");

    // interrupt: status sticky, masked, cleared by writing one
    chk_reg(PDC_STATUS_OFS, 32'h3);
    `CHK(irq, 1'b0)
    wr(PDC_MASK_OFS, 32'h2);
    chk_reg(PDC_MASK_OFS, 32'h2);
    `CHK(irq, 1'b1)
    wr(PDC_STATUS_OFS, 32'h2);
    chk_reg(PDC_STATUS_OFS, 32'h1);
    `CHK(irq, 1'b0)
    $display("test interrupt done");

    // non-bcd preset raises the error flag and its event
    wr(PDC_MASK_OFS, 32'h4);
    wr(PDC_UD_PRESET_OFS, 32'h00a5);
    chk_reg(PDC_STATUS_OFS, 32'h5);
    `CHK(operand_error_flag, 1'b1)
    `CHK(irq, 1'b1)
    wr(PDC_UD_PRESET_OFS, i2b(p));
    wr(PDC_STATUS_OFS, 32'h7);
    chk_reg(PDC_STATUS_OFS, 32'h0);
    `CHK(operand_error_flag, 1'b0)
    `CHK(irq, 1'b0)
    $display("test bcd error done");
    final_report();
  end
endmodule : testbench

/* verilog/pdc_counter.sv */
// preset down counter and reversible circular counter, bcd coded
// assumes count pins are asynchronous; exec_strobe comes from local logic
//
// The implementer's own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
module pdc_counter import pdc_pkg::*; (
  input wire logic clock,
  input wire logic rst,
  input wire pdc_bus_type bus,
  output logic [31:0] rd_data,
  input wire pdc_pins_type pins,
  input wire logic exec_strobe,
  input wire logic interlock,
  output logic dn_done,
  output logic ud_done,
  output logic operand_error_flag,
  output logic irq
);

  // ----------------------------------------------------------------
  // pin synchronisers and previous-execution levels
  // ----------------------------------------------------------------
  pdc_pins_type pin_s1_ff;
  pdc_pins_type pin_s2_ff;
  pdc_pins_type prev_ff;
  logic exec;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pin_s1_ff <= PDC_PINS_RST;
      pin_s2_ff <= PDC_PINS_RST;
    end else begin
      pin_s1_ff <= pins;
      pin_s2_ff <= pin_s1_ff;
    end
  end

  // an interlocked section is simply not executed: nothing moves
  assign exec = exec_strobe && !interlock; // [RL6] [RL16]

  // levels only advance on executions, so edges span strobe gaps
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      prev_ff <= PDC_PINS_RST;
    end else if (exec) begin
      prev_ff <= pin_s2_ff; // [RL17]
    end
  end

  logic cp_rise;
  logic dn_rst_rise;
  logic ii_rise;
  logic di_rise;
  logic ud_rst_rise;

  always_comb begin
    cp_rise = exec && pin_s2_ff.count_pulse_input
      && !prev_ff.count_pulse_input; // [RL17]
    dn_rst_rise = exec && pin_s2_ff.dn_reset_input
      && !prev_ff.dn_reset_input;
    ii_rise = exec && pin_s2_ff.increment_input
      && !prev_ff.increment_input;
    di_rise = exec && pin_s2_ff.decrement_input
      && !prev_ff.decrement_input;
    ud_rst_rise = exec && pin_s2_ff.ud_reset_input
      && !prev_ff.ud_reset_input;
  end

  // ----------------------------------------------------------------
  // registers written by software
  // ----------------------------------------------------------------
  logic [15:0] dn_preset_ff;
  logic [15:0] ud_preset_ff;
  logic [PDC_EV_W-1:0] mask_ff;
  logic wr_dn_preset;
  logic wr_ud_preset;
  logic wr_mask;
  logic wr_status;

  assign wr_dn_preset = bus.wr && bus.addr == PDC_DN_PRESET_OFS;
  assign wr_ud_preset = bus.wr && bus.addr == PDC_UD_PRESET_OFS;
  assign wr_mask = bus.wr && bus.addr == PDC_MASK_OFS;
  assign wr_status = bus.wr && bus.addr == PDC_STATUS_OFS;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dn_preset_ff <= PDC_PRESET_RST;
      ud_preset_ff <= PDC_PRESET_RST;
    end else begin
      // one 16-bit bcd word each, top digit caps count at 9999
      if (wr_dn_preset) begin
        dn_preset_ff <= bus.wdata[15:0]; // [RL7]
      end
      if (wr_ud_preset) begin
        ud_preset_ff <= bus.wdata[15:0]; // [RL7]
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mask_ff <= PDC_EVT_RST;
    end else if (wr_mask) begin
      mask_ff <= bus.wdata[PDC_EV_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // down counter
  // ----------------------------------------------------------------
  logic [15:0] dn_count_ff;
  logic dn_done_ff;
  logic dn_dec_ev;
  logic [15:0] nxt_dn_count;

  // zero is sticky: further pulses are ignored until a reload
  assign dn_dec_ev = cp_rise && !pin_s2_ff.dn_reset_input
    && dn_count_ff != PDC_ZERO; // [RL1] [RL5] [RL18]

  always_comb begin
    nxt_dn_count = dn_count_ff; // [RL2]
    if (dn_rst_rise) begin
      nxt_dn_count = dn_preset_ff; // [RL4]
    end else if (dn_dec_ev) begin
      nxt_dn_count = bcd_dec(dn_count_ff); // [RL1]
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dn_count_ff <= PDC_COUNT_RST;
    end else begin
      dn_count_ff <= nxt_dn_count;
    end
  end

  // done follows the count, so it holds until a reload moves it
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dn_done_ff <= 1'b0;
    end else begin
      dn_done_ff <= nxt_dn_count == PDC_ZERO; // [RL3]
    end
  end

  // ----------------------------------------------------------------
  // reversible circular counter
  // ----------------------------------------------------------------
  logic [15:0] ud_count_ff;
  logic ud_done_ff;
  logic ud_inc_ev;
  logic ud_dec_ev;
  logic ud_inc_wrap;
  logic ud_dec_wrap;

  // both edges at once cancel out
  assign ud_inc_ev = ii_rise && !di_rise
    && !pin_s2_ff.ud_reset_input; // [RL10] [RL12] [RL15]
  assign ud_dec_ev = di_rise && !ii_rise
    && !pin_s2_ff.ud_reset_input; // [RL11] [RL12] [RL15]
  // >= also catches a count left above a lowered preset
  assign ud_inc_wrap = ud_inc_ev && ud_count_ff >= ud_preset_ff;
  assign ud_dec_wrap = ud_dec_ev && ud_count_ff == PDC_ZERO;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ud_count_ff <= PDC_COUNT_RST;
    end else if (ud_rst_rise) begin
      ud_count_ff <= PDC_ZERO; // [RL15]
    end else if (ud_inc_wrap) begin
      ud_count_ff <= PDC_ZERO; // [RL9] [RL14]
    end else if (ud_inc_ev) begin
      ud_count_ff <= bcd_inc(ud_count_ff); // [RL10]
    end else if (ud_dec_wrap) begin
      ud_count_ff <= ud_preset_ff; // [RL9] [RL13]
    end else if (ud_dec_ev) begin
      ud_count_ff <= bcd_dec(ud_count_ff); // [RL11]
    end
  end

  // done stands from a wrap until the next count of either kind or a rising reversible reset
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ud_done_ff <= 1'b0;
    end else if (ud_rst_rise) begin
      ud_done_ff <= 1'b0;
    end else if (ud_inc_ev || ud_dec_ev) begin
      ud_done_ff <= ud_inc_wrap || ud_dec_wrap; // [RL13] [RL14]
    end
  end

  // ----------------------------------------------------------------
  // operand error, status and interrupt
  // ----------------------------------------------------------------
  logic err_ff;
  logic nxt_err;
  logic [PDC_EV_W-1:0] status_ff;
  logic [PDC_EV_W-1:0] ev_set;

  // counting keeps going on a bad preset; results are then garbage
  assign nxt_err = !is_bcd(dn_preset_ff)
    || !is_bcd(ud_preset_ff); // [RL8]

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      err_ff <= 1'b0;
    end else begin
      err_ff <= nxt_err; // [RL8]
    end
  end

  always_comb begin
    ev_set = PDC_EVT_RST;
    ev_set[PDC_EV_DN_DONE] = nxt_dn_count == PDC_ZERO && !dn_done_ff;
    ev_set[PDC_EV_UD_WRAP] = ud_inc_wrap || ud_dec_wrap;
    ev_set[PDC_EV_BCD_ERR] = nxt_err && !err_ff;
  end

  // set is or-ed after the clear so a same-cycle event survives
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      status_ff <= PDC_EVT_RST;
    end else if (wr_status) begin
      status_ff <= (status_ff & ~bus.wdata[PDC_EV_W-1:0]) | ev_set;
    end else begin
      status_ff <= status_ff | ev_set;
    end
  end

  assign irq = |(status_ff & mask_ff);
  assign dn_done = dn_done_ff;
  assign ud_done = ud_done_ff;
  assign operand_error_flag = err_ff;

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  logic [31:0] rd_data_ff;
  logic [31:0] nxt_rd_data;

  always_comb begin
    nxt_rd_data = '0;
    if (bus.rd) begin
      unique case (bus.addr)
        PDC_DN_PRESET_OFS: nxt_rd_data[15:0] = dn_preset_ff;
        PDC_DN_COUNT_OFS: nxt_rd_data[15:0] = dn_count_ff;
        PDC_UD_PRESET_OFS: nxt_rd_data[15:0] = ud_preset_ff;
        PDC_UD_COUNT_OFS: nxt_rd_data[15:0] = ud_count_ff;
        PDC_STATUS_OFS: nxt_rd_data[PDC_EV_W-1:0] = status_ff;
        PDC_MASK_OFS: nxt_rd_data[PDC_EV_W-1:0] = mask_ff;
        PDC_FLAGS_OFS: nxt_rd_data[PDC_EV_W-1:0] =
          {err_ff, ud_done_ff, dn_done_ff};
        default: nxt_rd_data = '0;
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rd_data_ff <= '0;
    end else begin
      rd_data_ff <= nxt_rd_data;
    end
  end

  assign rd_data = rd_data_ff;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  logic dn_hold;
  assign dn_hold = !dn_rst_rise && !dn_dec_ev;

  sequence s_dn_dec;
    dn_dec_ev;
  endsequence

  sequence s_dn_load;
    dn_rst_rise;
  endsequence

  property p_dn_dec;
    @(posedge clock) disable iff (rst)
    s_dn_dec |=> dn_count_ff == bcd_dec($past(dn_count_ff));
  endproperty
  a_dn_dec: assert property (p_dn_dec) // [RL1]
    else $error("down count did not drop by one");

  property p_dn_hold;
    @(posedge clock) disable iff (rst)
    dn_hold |=> $stable(dn_count_ff);
  endproperty
  a_dn_hold: assert property (p_dn_hold) // [RL2]
    else $error("down count moved without a count edge");

  property p_dn_done;
    @(posedge clock) disable iff (rst)
    dn_count_ff == PDC_ZERO && !$past(rst) |-> dn_done;
  endproperty
  a_dn_done: assert property (p_dn_done) // [RL3]
    else $error("down done flag missing at zero");

  property p_dn_load;
    @(posedge clock) disable iff (rst)
    s_dn_load |=> dn_count_ff == $past(dn_preset_ff);
  endproperty
  a_dn_load: assert property (p_dn_load) // [RL4]
    else $error("down count not reloaded from preset");

  property p_dn_rst_on;
    @(posedge clock) disable iff (rst)
    pin_s2_ff.dn_reset_input && !dn_rst_rise |=> $stable(dn_count_ff);
  endproperty
  a_dn_rst_on: assert property (p_dn_rst_on) // [RL5]
    else $error("down count moved while reset held");

  property p_dn_zero;
    @(posedge clock) disable iff (rst)
    dn_count_ff == PDC_ZERO && !dn_rst_rise ##1 !dn_rst_rise
      |=> dn_count_ff == PDC_ZERO;
  endproperty
  a_dn_zero: assert property (p_dn_zero) // [RL18]
    else $error("down count left zero without reset");

  property p_err;
    @(posedge clock) disable iff (rst)
    !is_bcd(dn_preset_ff) || !is_bcd(ud_preset_ff)
      |=> operand_error_flag;
  endproperty
  a_err: assert property (p_err) // [RL8]
    else $error("operand error flag not raised for bad preset");

  property p_ud_inc;
    @(posedge clock) disable iff (rst)
    ud_inc_ev && !ud_inc_wrap && !ud_rst_rise
      |=> ud_count_ff == bcd_inc($past(ud_count_ff));
  endproperty
  a_ud_inc: assert property (p_ud_inc) // [RL10]
    else $error("reversible count did not rise by one");

  property p_ud_dec;
    @(posedge clock) disable iff (rst)
    ud_dec_ev && !ud_dec_wrap && !ud_rst_rise
      |=> ud_count_ff == bcd_dec($past(ud_count_ff));
  endproperty
  a_ud_dec: assert property (p_ud_dec) // [RL11]
    else $error("reversible count did not drop by one");

  property p_ud_both;
    @(posedge clock) disable iff (rst)
    ii_rise && di_rise && !ud_rst_rise |=> $stable(ud_count_ff);
  endproperty
  a_ud_both: assert property (p_ud_both) // [RL12]
    else $error("reversible count moved on two edges");

  property p_ud_dec_wrap;
    @(posedge clock) disable iff (rst)
    ud_dec_wrap && !ud_rst_rise
      |=> ud_count_ff == $past(ud_preset_ff) && ud_done;
  endproperty
  a_ud_dec_wrap: assert property (p_ud_dec_wrap) // [RL13]
    else $error("underflow did not wrap to preset");

  property p_ud_inc_wrap;
    @(posedge clock) disable iff (rst)
    ud_inc_wrap && !ud_rst_rise |=> ud_count_ff == PDC_ZERO && ud_done;
  endproperty
  a_ud_inc_wrap: assert property (p_ud_inc_wrap) // [RL14]
    else $error("overflow did not wrap to zero");

  property p_ud_rst;
    @(posedge clock) disable iff (rst)
    ud_rst_rise |=> ud_count_ff == PDC_ZERO && !ud_done;
  endproperty
  a_ud_rst: assert property (p_ud_rst) // [RL15]
    else $error("reversible reset did not clear and hold");

  property p_ud_rst_on;
    @(posedge clock) disable iff (rst)
    pin_s2_ff.ud_reset_input && !ud_rst_rise |=> $stable(ud_count_ff);
  endproperty
  a_ud_rst_on: assert property (p_ud_rst_on) // [RL15]
    else $error("reversible count moved while reset held");

  property p_interlock;
    @(posedge clock) disable iff (rst)
    !exec |=> $stable(dn_count_ff) && $stable(ud_count_ff);
  endproperty
  a_interlock: assert property (p_interlock) // [RL6] [RL16]
    else $error("count changed without execution");

endmodule : pdc_counter

/* verilog/pdc_pkg.sv */
// constants, carriers and bcd helpers of the preset counter unit
// assumes one 200 MHz clock and a plain strobe register port
//
// Contract
// RL1: down counter decrements on strobe when count pulse rose since last strobe
// RL2: down count holds when count pulse is steady or has fallen
// RL3: down done flag sets at zero count and stays until counter reset
// RL4: rising down reset input reloads the down count with its preset
// RL5: no decrement while down reset is on; counting resumes after release
// RL6: down count survives interlock and is kept while not executed
// RL7: preset is one 16-bit bcd word, so counts reach at most 9999
// RL8: non-bcd preset keeps running but raises the operand error flag
// RL9: reversible counter runs circularly between zero and its preset
// RL10: reversible counter adds one when increment input rose since last strobe
// RL11: reversible counter subtracts one when decrement input rose
// RL12: both inputs rising together leave the reversible count unchanged
// RL13: decrement at 0000 wraps to preset and sets done until next count
// RL14: increment past preset wraps to 0000 and sets done until next count
// RL15: rising reversible reset clears count; no counting while it stays on
// RL16: reversible count survives interlock and is kept while not executed
// RL17: each count input keeps its level at last strobe; edges seen on strobes
// RL18: a down count at zero stays at zero until the next reset
package pdc_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] PDC_DN_PRESET_OFS = 8'h00;
  localparam logic [7:0] PDC_DN_COUNT_OFS = 8'h04;
  localparam logic [7:0] PDC_UD_PRESET_OFS = 8'h08;
  localparam logic [7:0] PDC_UD_COUNT_OFS = 8'h0c;
  localparam logic [7:0] PDC_STATUS_OFS = 8'h10;
  localparam logic [7:0] PDC_MASK_OFS = 8'h14;
  localparam logic [7:0] PDC_FLAGS_OFS = 8'h18;

  localparam logic [15:0] PDC_PRESET_RST = 16'h0000;
  localparam logic [15:0] PDC_COUNT_RST = 16'h0000;
  localparam logic [15:0] PDC_ZERO = 16'h0000;
  localparam logic [2:0] PDC_EVT_RST = 3'h0;

  // event bits of status, mask and flags registers
  localparam int PDC_EV_DN_DONE = 0;
  localparam int PDC_EV_UD_WRAP = 1;
  localparam int PDC_EV_BCD_ERR = 2;
  localparam int PDC_EV_W = 3;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } pdc_bus_type;

  typedef struct packed {
    logic count_pulse_input;
    logic dn_reset_input;
    logic increment_input;
    logic decrement_input;
    logic ud_reset_input;
  } pdc_pins_type;

  localparam pdc_pins_type PDC_PINS_RST = '0;

  // ----------------------------------------------------------------
  // bcd helpers
  // ----------------------------------------------------------------
  function automatic logic is_bcd(input logic [15:0] v);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < 4; i++) begin
      if (v[i*4 +: 4] > 4'h9) begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction : is_bcd

  function automatic logic [15:0] bcd_inc(input logic [15:0] v);
    logic [15:0] r;
    logic c;
    r = v;
    c = 1'b1;
    for (int i = 0; i < 4; i++) begin
      if (c) begin
        if (r[i*4 +: 4] >= 4'h9) begin
          r[i*4 +: 4] = 4'h0;
        end else begin
          r[i*4 +: 4] = r[i*4 +: 4] + 4'h1;
          c = 1'b0;
        end
      end
    end
    return r;
  endfunction : bcd_inc

  function automatic logic [15:0] bcd_dec(input logic [15:0] v);
    logic [15:0] r;
    logic b;
    r = v;
    b = 1'b1;
    for (int i = 0; i < 4; i++) begin
      if (b) begin
        if (r[i*4 +: 4] == 4'h0) begin
          r[i*4 +: 4] = 4'h9;
        end else begin
          r[i*4 +: 4] = r[i*4 +: 4] - 4'h1;
          b = 1'b0;
        end
      end
    end
    return r;
  endfunction : bcd_dec

endpackage : pdc_pkg
